// ==== dv/bstp_jtag_host.sv ====
// Test controller model driving the four-pin test port
`timescale 1ns/1ps
`default_nettype none
module bstp_jtag_host (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // Clock rests low between frames, mode high keeps the port parked
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One test clock: mode and data set ahead of the rise, out sampled late in low phase
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #40 o = tdo;
        tck = 1'b1;
        #40 tck = 1'b0;
    endtask
    // Mode pattern lsb first; five ones give a guaranteed reset
    task automatic walk(input logic [7:0] p, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(p[i], 1'b0, o);
        end
    endtask
    // Shift n bits lsb first, the last one leaves the shift state
    task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
    endtask
endmodule
`default_nettype wire

// ==== dv/bstp_tap_bench.sv ====
// Bench for the test port: scans, stream, pad and probe control
`timescale 1ns/1ps
`default_nettype none
module bstp_tap_bench;
    logic clk_sys = 0, rst_n = 0, ce = 1, probe_mode_pin = 0, fuse_secured = 0;
    logic probe_data_a = 1, probe_data_b = 0, upd_ready = 0;
    logic tck_pin, tms_pin, tdi_pin, tdo_o, tdo_oe_n, upd_valid, upd_room;
    logic [7:0] io_pin_i = 8'ha5, core_o = 8'h33, core_oe_n = 8'h0f, io_o, io_oe_n;
    // User side only drives its probe pins; pin 2 is left unassigned
    logic [4:0] pp_pin_i = 5'h1c, user_o = 5'h15, user_oe_n = 5'h00, user_used = 5'h1b;
    logic [4:0] pp_o, pp_oe_n, user_i;
    logic [2:0] probe_in;
    logic [3:0] tap_state;
    logic [31:0] r;
    bstp_pkg::bstp_upd_s upd_data;
    int err_total = 0, compares = 0;
    bstp_tap dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .tck_pin(tck_pin), .tms_pin(tms_pin),
        .tdi_pin(tdi_pin), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .probe_mode_pin(probe_mode_pin),
        .fuse_secured(fuse_secured), .io_pin_i(io_pin_i), .core_o(core_o), .core_oe_n(core_oe_n),
        .io_o(io_o), .io_oe_n(io_oe_n), .pp_pin_i(pp_pin_i), .user_o(user_o),
        .user_oe_n(user_oe_n), .user_used(user_used), .probe_data_a(probe_data_a),
        .probe_data_b(probe_data_b), .pp_o(pp_o), .pp_oe_n(pp_oe_n), .user_i(user_i),
        .probe_in(probe_in), .upd_valid(upd_valid), .upd_ready(upd_ready), .upd_data(upd_data),
        .upd_room(upd_room), .tap_state(tap_state)
    );
    // Released serial out floats to its pull-up level at the controller
    bstp_jtag_host h (.tck(tck_pin), .tms(tms_pin), .tdi(tdi_pin), .tdo(tdo_oe_n ? 1'b1 : tdo_o));
    // System clock, 4 ns
    always #2 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic w;
        repeat (8) @(negedge clk_sys);
    endtask
    // Load an instruction from idle; synced pins need a few clocks to land
    task automatic ir(input logic [3:0] c);
        h.walk(8'h03, 4);
        h.scan(4, {28'h0, c}, r);
        h.walk(8'h01, 2);
        w;
    endtask
    task automatic dr(input int n, input logic [31:0] d);
        h.walk(8'h01, 3);
        h.scan(n, d, r);
        h.walk(8'h01, 2);
        w;
    endtask
    task automatic t_idcode;
        dr(32, 32'h0);
        chk("idcode", bstp_pkg::ID_VALUE, r);
        chk("idle_state", 32'h1, tap_state);
        chk("tdo_off", 32'h1, tdo_oe_n);
    endtask
    // Unknown codes fall back to the one-bit path
    task automatic t_bypass;
        logic [3:0] c[2] = '{bstp_pkg::INS_BYPASS, 4'h7};
        foreach (c[i]) begin
            ir(c[i]);
            chk("ir_capture", bstp_pkg::IR_CAPTURE, r);
            dr(2, 32'h1);
            chk("bypass", 32'h2, r);
        end
    endtask
    task automatic t_sample;
        ir(bstp_pkg::INS_SAMPLE);
        dr(8, 32'h3c);
        chk("capture", 32'ha5, r);
        chk("upd_valid", 32'h1, upd_valid);
        chk("upd_data", 32'h03c, upd_data);
        // Eight more updates fill the buffer behind the held word
        repeat (8) dr(1, 32'h0);
        chk("upd_room", 32'h0, upd_room);
        chk("upd_held", 32'h03c, upd_data);
        upd_ready = 1'b1;
        w;
        w;
        chk("upd_drained", 32'h0, upd_valid);
        chk("upd_room_back", 32'h1, upd_room);
    endtask
    // Frozen enable hides a test clock; a mid-run reset returns to TLR
    task automatic t_freeze;
        ce = 1'b0;
        h.walk(8'h01, 1);
        ce = 1'b1;
        w;
        chk("frozen", 32'h1, tap_state);
        h.walk(8'h01, 1);
        w;
        chk("sel_dr", 32'h2, tap_state);
        rst_n = 1'b0;
        w;
        chk("mid_rst", 32'h0, tap_state);
        rst_n = 1'b1;
        w;
        chk("mid_tdo", 32'h1, tdo_oe_n);
        h.walk(8'h00, 1);
    endtask
    // Pads follow the update latch, then a mode-high reset frees them
    task automatic t_extest;
        ir(bstp_pkg::INS_EXTEST);
        dr(8, 32'h5a);
        chk("io_o", 32'h5a, io_o);
        chk("io_oe_n", 32'h0, io_oe_n);
        h.walk(8'h1f, 5);
        w;
        chk("reset_state", 32'h0, tap_state);
        chk("io_free", core_oe_n, io_oe_n);
        h.walk(8'h00, 1);
        t_idcode;
    endtask
    task automatic t_probe;
        chk("user_oe", 32'h04, pp_oe_n);
        chk("user_i", 32'h1c, user_i);
        probe_mode_pin = 1'b1;
        w;
        chk("probe_oe", 32'h0, pp_oe_n[1:0]);
        chk("probe_out", 32'h1, pp_o[1:0]);
        chk("probe_in", 32'h7, probe_in);
        fuse_secured = 1'b1;
        w;
        chk("locked_o", 32'h11, pp_o);
        chk("locked_oe", 32'h04, pp_oe_n);
        chk("locked_in", 32'h0, probe_in);
        user_used = 5'h00;
        w;
        chk("unused", 32'h1f, pp_oe_n);
    endtask
    task automatic final_report;
        $display("err_total %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence, inputs change on the falling edge
    initial begin
        repeat (5) @(negedge clk_sys);
        chk("rst_state", 32'h0, tap_state);
        chk("rst_tdo", 32'h1, tdo_oe_n);
        rst_n = 1'b1;
        w;
        h.walk(8'h00, 1);
        t_idcode;
        t_bypass;
        t_sample;
        t_extest;
        t_freeze;
        t_probe;
        final_report;
    end
    // Run takes about 20 us; cut a hang at five times that
    initial begin
        #100000;
        err_total++;
        final_report;
    end
endmodule
`default_nettype wire

// ==== logic/bstp_fifo.sv ====
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bstp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    logic         push;
    logic         pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready  = (wr_q != {~rd_q[AW], rd_q[AW-1:0]});
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage
    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (ce) begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/bstp_pkg.sv ====
// Package: constants, types and carriers for the boundary-scan test port
package bstp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int IR_W       = 4;
    localparam int NUM_IO     = 8;
    localparam int PP_W       = 5;
    localparam int FIFO_DEPTH = 8;
    localparam int TMS_RST_N  = 5;

    // Probe pin positions in the probe pin group
    localparam int PP_A    = 0;
    localparam int PP_B    = 1;
    localparam int PP_SIN  = 2;
    localparam int PP_SOUT = 3;
    localparam int PP_SCLK = 4;

    // ------------------------------------------------------------------
    // Instructions and capture pattern
    // ------------------------------------------------------------------
    localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INS_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

    // Identification fields; values are arbitrary
    localparam logic [3:0]  ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART    = 16'h0a5c;
    localparam logic [3:0]  ID_NUMBER  = 4'h3;
    localparam logic [7:0]  ID_LSB     = 8'h01;
    localparam logic [31:0] ID_VALUE   = {ID_VERSION, ID_PART, ID_NUMBER, ID_LSB};

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } bstp_tap_e;

    // One boundary update handed to the user side
    typedef struct packed {
        logic              extest;
        logic [NUM_IO-1:0] val;
    } bstp_upd_s;

    // Synchronised pin group
    typedef struct packed {
        logic              tck;
        logic              tms;
        logic              tdi;
        logic              mode;
        logic              fuse;
        logic [NUM_IO-1:0] io;
        logic [PP_W-1:0]   pp;
    } bstp_pins_s;

endpackage

// ==== logic/bstp_sync.sv ====
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module bstp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce) begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule
`default_nettype wire

// ==== logic/bstp_tap.sv ====
// Boundary-scan test access port with probe pin control
`timescale 1ns/1ps
`default_nettype none
module bstp_tap (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    // Test pins
    input  wire logic                       tck_pin,
    input  wire logic                       tms_pin,
    input  wire logic                       tdi_pin,
    output logic                            tdo_o,
    output logic                            tdo_oe_n,
    // Probe configuration
    input  wire logic                       probe_mode_pin,
    input  wire logic                       fuse_secured,
    // Boundary pins and core side
    input  wire logic [bstp_pkg::NUM_IO-1:0] io_pin_i,
    input  wire logic [bstp_pkg::NUM_IO-1:0] core_o,
    input  wire logic [bstp_pkg::NUM_IO-1:0] core_oe_n,
    output logic      [bstp_pkg::NUM_IO-1:0] io_o,
    output logic      [bstp_pkg::NUM_IO-1:0] io_oe_n,
    // Probe pins and user side
    input  wire logic [bstp_pkg::PP_W-1:0]  pp_pin_i,
    input  wire logic [bstp_pkg::PP_W-1:0]  user_o,
    input  wire logic [bstp_pkg::PP_W-1:0]  user_oe_n,
    input  wire logic [bstp_pkg::PP_W-1:0]  user_used,
    input  wire logic                       probe_data_a,
    input  wire logic                       probe_data_b,
    output logic      [bstp_pkg::PP_W-1:0]  pp_o,
    output logic      [bstp_pkg::PP_W-1:0]  pp_oe_n,
    output logic      [bstp_pkg::PP_W-1:0]  user_i,
    output logic      [2:0]                 probe_in,
    // Boundary update stream and controller state
    output logic                            upd_valid,
    input  wire logic                       upd_ready,
    output bstp_pkg::bstp_upd_s             upd_data,
    output logic                            upd_room,
    output logic      [3:0]                 tap_state
);
    // ------------------------------------------------------------------
    // Pin synchronisation and clock edge detection
    // ------------------------------------------------------------------
    bstp_pkg::bstp_pins_s pins_s;
    logic                 tck_d_q;
    logic                 tck_rise;
    logic                 tck_fall;

    bstp_sync #(
        .W ($bits(bstp_pkg::bstp_pins_s))
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .din     ({tck_pin, tms_pin, tdi_pin, probe_mode_pin, fuse_secured,
                   io_pin_i, pp_pin_i}),
        .dout    (pins_s)
    );

    // Test clock is sampled, never used as a clock
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tck_d_q <= 1'b0;
        end else if (ce) begin
            tck_d_q <= pins_s.tck;
        end
    end

    assign tck_rise = pins_s.tck && !tck_d_q;
    assign tck_fall = !pins_s.tck && tck_d_q;

    // ------------------------------------------------------------------
    // Controller state machine
    // ------------------------------------------------------------------
    bstp_pkg::bstp_tap_e st_q;
    bstp_pkg::bstp_tap_e st_d;

    // Standard sixteen-state graph steered by the mode level
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            bstp_pkg::ST_TLR:    st_d = pins_s.tms ? bstp_pkg::ST_TLR    : bstp_pkg::ST_RTI;
            bstp_pkg::ST_RTI:    st_d = pins_s.tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_RTI;
            bstp_pkg::ST_SEL_DR: st_d = pins_s.tms ? bstp_pkg::ST_SEL_IR : bstp_pkg::ST_CAP_DR;
            bstp_pkg::ST_CAP_DR: st_d = pins_s.tms ? bstp_pkg::ST_EX1_DR : bstp_pkg::ST_SH_DR;
            bstp_pkg::ST_SH_DR:  st_d = pins_s.tms ? bstp_pkg::ST_EX1_DR : bstp_pkg::ST_SH_DR;
            bstp_pkg::ST_EX1_DR: st_d = pins_s.tms ? bstp_pkg::ST_UPD_DR : bstp_pkg::ST_PA_DR;
            bstp_pkg::ST_PA_DR:  st_d = pins_s.tms ? bstp_pkg::ST_EX2_DR : bstp_pkg::ST_PA_DR;
            bstp_pkg::ST_EX2_DR: st_d = pins_s.tms ? bstp_pkg::ST_UPD_DR : bstp_pkg::ST_SH_DR;
            bstp_pkg::ST_UPD_DR: st_d = pins_s.tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_RTI;
            bstp_pkg::ST_SEL_IR: st_d = pins_s.tms ? bstp_pkg::ST_TLR    : bstp_pkg::ST_CAP_IR;
            bstp_pkg::ST_CAP_IR: st_d = pins_s.tms ? bstp_pkg::ST_EX1_IR : bstp_pkg::ST_SH_IR;
            bstp_pkg::ST_SH_IR:  st_d = pins_s.tms ? bstp_pkg::ST_EX1_IR : bstp_pkg::ST_SH_IR;
            bstp_pkg::ST_EX1_IR: st_d = pins_s.tms ? bstp_pkg::ST_UPD_IR : bstp_pkg::ST_PA_IR;
            bstp_pkg::ST_PA_IR:  st_d = pins_s.tms ? bstp_pkg::ST_EX2_IR : bstp_pkg::ST_PA_IR;
            bstp_pkg::ST_EX2_IR: st_d = pins_s.tms ? bstp_pkg::ST_UPD_IR : bstp_pkg::ST_SH_IR;
            bstp_pkg::ST_UPD_IR: st_d = pins_s.tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_RTI;
        endcase
    end

    // Moves only on a sampled test clock rise; reset puts it in TLR
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= bstp_pkg::ST_TLR;
        end else if (ce && tck_rise) begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Instruction register and decode
    // ------------------------------------------------------------------
    localparam bit ID_PRESENT = 1'b1;
    localparam logic [bstp_pkg::IR_W-1:0] INS_RESET =
        ID_PRESENT ? bstp_pkg::INS_IDCODE : bstp_pkg::INS_BYPASS;

    logic [bstp_pkg::IR_W-1:0] ir_sh_q;
    logic [bstp_pkg::IR_W-1:0] ir_q;
    logic                      sel_bs;
    logic                      sel_id;
    logic                      sel_byp;
    logic                      extest;

    // Unknown codes fall back to bypass
    assign extest  = (ir_q == bstp_pkg::INS_EXTEST);
    assign sel_bs  = extest || (ir_q == bstp_pkg::INS_SAMPLE);
    assign sel_id  = ID_PRESENT && (ir_q == bstp_pkg::INS_IDCODE);
    assign sel_byp = !sel_bs && !sel_id;

    // Shift stage works only in instruction states
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ir_sh_q <= '0;
        end else if (ce && tck_rise) begin
            if (st_q == bstp_pkg::ST_CAP_IR) begin
                ir_sh_q <= bstp_pkg::IR_CAPTURE;
            end else if (st_q == bstp_pkg::ST_SH_IR) begin
                ir_sh_q <= {pins_s.tdi, ir_sh_q[bstp_pkg::IR_W-1:1]};
            end
        end
    end

    // Loaded on the way into TLR so the reset state already holds it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ir_q <= INS_RESET;
        end else if (ce && tck_rise) begin
            if (st_d == bstp_pkg::ST_TLR) begin
                ir_q <= INS_RESET;
            end else if (st_q == bstp_pkg::ST_UPD_IR) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    logic                      byp_q;
    logic [31:0]               id_sh_q;
    logic [bstp_pkg::NUM_IO-1:0] bs_sh_q;
    logic [bstp_pkg::NUM_IO-1:0] bs_upd_q;
    logic                      ext_q;
    logic                      push_q;
    logic                      dr_cap;
    logic                      dr_sh;

    assign dr_cap = tck_rise && (st_q == bstp_pkg::ST_CAP_DR);
    assign dr_sh  = tck_rise && (st_q == bstp_pkg::ST_SH_DR);

    // Bypass: single stage, captures zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            byp_q <= 1'b0;
        end else if (ce && sel_byp) begin
            if (dr_cap) begin
                byp_q <= 1'b0;
            end else if (dr_sh) begin
                byp_q <= pins_s.tdi;
            end
        end
    end

    // Identification: fixed pattern, shifted out lsb first
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            id_sh_q <= '0;
        end else if (ce && sel_id) begin
            if (dr_cap) begin
                id_sh_q <= bstp_pkg::ID_VALUE;
            end else if (dr_sh) begin
                id_sh_q <= {pins_s.tdi, id_sh_q[31:1]};
            end
        end
    end

    // Boundary chain: one stage per pin, captured from the pads
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bs_sh_q <= '0;
        end else if (ce && sel_bs) begin
            if (dr_cap) begin
                bs_sh_q <= pins_s.io;
            end else if (dr_sh) begin
                bs_sh_q <= {pins_s.tdi, bs_sh_q[bstp_pkg::NUM_IO-1:1]};
            end
        end
    end

    // Update latch; drive permission tracks the current instruction
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bs_upd_q <= '0;
            ext_q    <= 1'b0;
            push_q   <= 1'b0;
        end else if (ce) begin
            push_q <= 1'b0;
            ext_q  <= extest && (st_q != bstp_pkg::ST_TLR);
            if (tck_rise && sel_bs && st_q == bstp_pkg::ST_UPD_DR) begin
                bs_upd_q <= bs_sh_q;
                push_q   <= 1'b1;
            end
        end
    end

    // Pads follow the core unless external test owns them
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            io_oe_n <= '1;
            io_o    <= '0;
        end else if (ce) begin
            io_o    <= ext_q ? bs_upd_q : core_o;
            io_oe_n <= ext_q ? '0 : core_oe_n;
        end
    end

    // ------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------
    logic tdo_src;
    logic shifting;

    assign shifting = (st_q == bstp_pkg::ST_SH_IR) || (st_q == bstp_pkg::ST_SH_DR);

    // Selected register's end bit
    always_comb begin
        tdo_src = byp_q;
        if (st_q == bstp_pkg::ST_SH_IR) begin
            tdo_src = ir_sh_q[0];
        end else if (sel_bs) begin
            tdo_src = bs_sh_q[0];
        end else if (sel_id) begin
            tdo_src = id_sh_q[0];
        end
    end

    // Changed on the fall so the far end samples a settled bit on the rise
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tdo_o    <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (ce && tck_fall) begin
            tdo_o    <= tdo_src;
            tdo_oe_n <= !shifting;
        end
    end

    // ------------------------------------------------------------------
    // Probe pins
    // ------------------------------------------------------------------
    logic probe_en;

    // A programmed fuse wins over the mode pin
    assign probe_en = pins_s.mode && !pins_s.fuse;

    // Per pin: probe role, user signal, or unused (released)
    for (genvar i = 0; i < bstp_pkg::PP_W; i++) begin : g_pp
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                pp_o[i]    <= 1'b0;
                pp_oe_n[i] <= 1'b1;
            end else if (ce) begin
                if (probe_en) begin
                    pp_o[i]    <= (i == bstp_pkg::PP_A) ? probe_data_a : probe_data_b;
                    pp_oe_n[i] <= (i > bstp_pkg::PP_B);
                end else begin
                    pp_o[i]    <= user_used[i] && user_o[i];
                    pp_oe_n[i] <= !user_used[i] || user_oe_n[i];
                end
            end
        end
    end

    // Probe inputs seen only while probing is allowed
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            user_i   <= '0;
            probe_in <= '0;
        end else if (ce) begin
            user_i   <= pins_s.pp;
            probe_in <= probe_en ? pins_s.pp[bstp_pkg::PP_SCLK:bstp_pkg::PP_SIN] : '0;
        end
    end

    // ------------------------------------------------------------------
    // Update stream buffer
    // ------------------------------------------------------------------
    logic                fifo_room;
    logic                fifo_valid;
    logic                fifo_pop;
    bstp_pkg::bstp_upd_s fifo_out;

    // An update that meets a full buffer is dropped; upd_room warns first
    bstp_fifo #(
        .W     ($bits(bstp_pkg::bstp_upd_s)),
        .DEPTH (bstp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (push_q),
        .in_ready  (fifo_room),
        .in_data   ({extest, bs_upd_q}),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    assign fifo_pop = fifo_valid && (!upd_valid || upd_ready);

    // Output stage keeps every port on a flop
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            upd_valid <= 1'b0;
            upd_data  <= '0;
            upd_room  <= 1'b1;
            tap_state <= '0;
        end else if (ce) begin
            upd_room  <= fifo_room;
            tap_state <= st_q;
            if (fifo_pop) begin
                upd_valid <= 1'b1;
                upd_data  <= fifo_out;
            end else if (upd_ready) begin
                upd_valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [2:0] tms_ones_q;

    // Consecutive test clock rises with mode high, saturating
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tms_ones_q <= '0;
        end else if (ce && tck_rise) begin
            if (!pins_s.tms) begin
                tms_ones_q <= '0;
            end else if (tms_ones_q != 3'(bstp_pkg::TMS_RST_N)) begin
                tms_ones_q <= tms_ones_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_TMS_RESET: assert property (
        tms_ones_q == 3'(bstp_pkg::TMS_RST_N) |-> st_q == bstp_pkg::ST_TLR)
        else $error("mode high five clocks did not reset controller");
    AST_STATE_HOLD: assert property (
        !tck_rise |=> $stable(st_q))
        else $error("state moved without test clock rise");
    AST_IR_ON_TLR: assert property (
        st_q == bstp_pkg::ST_TLR |-> ir_q == INS_RESET)
        else $error("reset state without identify instruction");
    AST_PADS_FREE: assert property (
        st_q == bstp_pkg::ST_TLR ##1 ce |=> io_oe_n == $past(core_oe_n))
        else $error("pads not under core control in reset state");
    AST_IR_ONLY: assert property (
        ce && (st_q != bstp_pkg::ST_CAP_IR) && (st_q != bstp_pkg::ST_SH_IR)
        |=> $stable(ir_sh_q))
        else $error("instruction stage moved outside instruction states");
    AST_BYP_CAP: assert property (
        ce && dr_cap && sel_byp |=> !byp_q)
        else $error("bypass did not capture zero");
    AST_ID_CAP: assert property (
        ce && dr_cap && sel_id |=> id_sh_q == bstp_pkg::ID_VALUE)
        else $error("identification capture wrong");
    AST_BS_CAP: assert property (
        ce && dr_cap && sel_bs |=> bs_sh_q == $past(pins_s.io))
        else $error("boundary capture wrong");
    AST_TDO_FALL: assert property (
        !tck_fall |=> $stable(tdo_o))
        else $error("serial out changed off a falling edge");
    AST_TDO_HIZ: assert property (
        ce && tck_fall && !shifting |=> tdo_oe_n)
        else $error("serial out driven outside shift states");
    AST_PROBE_LOCK: assert property (
        ce && pins_s.fuse && user_used[bstp_pkg::PP_A]
        |=> pp_o[bstp_pkg::PP_A] == $past(user_o[bstp_pkg::PP_A]))
        else $error("secured probe pin not given to user");
    AST_UNUSED: assert property (
        ce && !probe_en && !user_used[bstp_pkg::PP_SOUT] |=> pp_oe_n[bstp_pkg::PP_SOUT])
        else $error("unused probe pin driven");

    COV_UPD_IR: cover property (st_q == bstp_pkg::ST_UPD_IR && tck_rise);
    COV_EXTEST: cover property (ext_q && !io_oe_n[0]);
    COV_PROBE:  cover property (probe_en && !pp_oe_n[bstp_pkg::PP_A]);
    COV_FULL:   cover property (!fifo_room);
endmodule
`default_nettype wire
